// File: design/ccnt_consts.svh
// Constants for the charge integrator counter: register map, field positions, widths and reset values.
// How it works
// - Every sample accepted (measurement enabled, not frozen, awake or with non-zero period) adds into the accumulator and advances the tally by one.
// - Writing accum_clear zeroes accumulator, all three user copies and the tally.
// - Counter copies refresh on next read only after reset, a counter write or an access to another mapped register.
// - A qualifying counter read copies accumulator and tally into all three copies coherently.
// - Accumulator or tally overflow sets accum_overflow_fault; unmasked it drives the fault pin.
// - With clear_on_read_sel set, a counter read clears accumulator and tally after snapshot.
// - wrap_mode_sel 0 clamps the accumulator, 1 lets it roll over.
// - Passing upper or lower limit sets a sticky flag, cleared by writing 0.
// - Tally overflow sets a sticky flag cleared by 0; any overflow sets the fault bit.
// - In sleep, enabled with non-zero period, each wake-up sample at gain 256 integrates.
// - In sleep, crossing the threshold sets threshold flag and fault; masks gate wake and fault.
// - Leaving sleep freezes the accumulator until cleared; acquisition becomes continuous.
// - Conversions taken during chain diagnosis integrate like normal samples.
`ifndef CCNT_CONSTS_SVH
`define CCNT_CONSTS_SVH

`define CCNT_ACC_W 32
`define CCNT_HALF_W 16
`define CCNT_TALLY_W 16
`define CCNT_SAMPLE_W 16
`define CCNT_ADDR_W 12

// Register indices; the byte address is four times the index.
`define CCNT_IDX_CTRL 10'h001
`define CCNT_IDX_FLAGS 10'h002
`define CCNT_IDX_THRESH 10'h003
`define CCNT_IDX_STATUS 10'h004
`define CCNT_IDX_ACC_HIGH 10'h02d
`define CCNT_IDX_ACC_LOW 10'h02e
`define CCNT_IDX_TALLY 10'h02f

// Control register fields.
`define CCNT_CTRL_MEAS_EN 0
`define CCNT_CTRL_CLEAR 1
`define CCNT_CTRL_COR 2
`define CCNT_CTRL_WRAP 3
`define CCNT_CTRL_FAULT_MASK 4
`define CCNT_CTRL_WAKE_MASK 5
`define CCNT_CTRL_RESET 5'h00

// Flag register fields.
`define CCNT_FLAG_POS 0
`define CCNT_FLAG_NEG 1
`define CCNT_FLAG_TALLY 2
`define CCNT_FLAG_THRESH 3
`define CCNT_FLAG_FAULT 4

// Status register fields.
`define CCNT_STAT_SLEEP 0
`define CCNT_STAT_FROZEN 1

`define CCNT_THRESH_RESET 32'h7fffffff
`endif

// File: design/ccnt_pkg.sv
// Types shared by the charge integrator counter.
package ccnt_pkg;
  typedef struct packed {
    logic wake_mask;
    logic fault_mask;
    logic wrap_mode_sel;
    logic clear_on_read_sel;
    logic current_meas_enable;
  } ccnt_ctrl_t;

  typedef struct packed {
    logic accum_overflow_fault;
    logic sleep_threshold_flag;
    logic tally_overflow_flag;
    logic neg_underflow_flag;
    logic pos_overflow_flag;
  } ccnt_flags_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ccnt_sample_t;
endpackage : ccnt_pkg

// File: design/ccnt_top.sv
// Charge integrator counter with its APB register slave.
`include "ccnt_consts.svh"

module ccnt_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CCNT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Current converter results
  input wire ccnt_pkg::ccnt_sample_t conv_sample,
  // Power mode
  input wire logic sleep_mode,
  input wire logic cyclic_period_nonzero,
  // Outputs to the converter, wake and fault logic
  output logic pga_gain_256,
  output logic continuous_acq,
  output logic wake_request,
  output logic fault_out
);

  ccnt_pkg::ccnt_ctrl_t ctrl_reg;
  ccnt_pkg::ccnt_flags_t flags_reg;
  logic [`CCNT_ACC_W-1:0] thresh_reg;
  logic signed [`CCNT_ACC_W-1:0] acc_reg;
  logic [`CCNT_TALLY_W-1:0] tally_reg;
  logic [`CCNT_ACC_W-1:0] acc_copy_reg;
  logic [`CCNT_TALLY_W-1:0] tally_copy_reg;
  logic stale_reg;
  logic sleep_seen_reg;
  logic frozen_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pga_gain_256_reg;
  logic continuous_acq_reg;
  logic wake_request_reg;
  logic fault_out_reg;

  // Bus decode.
  logic [9:0] idx;
  logic setup_phase;
  logic wr_done;
  logic rd_setup;
  logic any_setup;
  logic is_counter;
  logic is_mapped;
  // Write strobes, one per writable register.
  logic ctrl_wr;
  logic flags_wr;
  logic thresh_wr;

  assign idx = paddr[`CCNT_ADDR_W-1:2];
  assign setup_phase = psel && !penable && !pready_reg;
  assign wr_done = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign rd_setup = setup_phase && !pwrite && is_mapped;
  assign any_setup = setup_phase && is_mapped;
  assign is_counter = (idx == `CCNT_IDX_ACC_HIGH) || (idx == `CCNT_IDX_ACC_LOW) || (idx == `CCNT_IDX_TALLY);
  assign is_mapped = is_counter || (idx == `CCNT_IDX_CTRL) || (idx == `CCNT_IDX_FLAGS) ||
                     (idx == `CCNT_IDX_THRESH) || (idx == `CCNT_IDX_STATUS);
  assign ctrl_wr = wr_done && (idx == `CCNT_IDX_CTRL);
  assign flags_wr = wr_done && (idx == `CCNT_IDX_FLAGS);
  assign thresh_wr = wr_done && (idx == `CCNT_IDX_THRESH);

  // Snapshot and clear events.
  logic counter_read;
  logic take_snapshot;
  logic clear_write;
  logic clear_read;
  logic clear_now;

  assign counter_read = rd_setup && is_counter;
  assign take_snapshot = counter_read && stale_reg;
  assign clear_write = ctrl_wr && pwdata[`CCNT_CTRL_CLEAR];
  assign clear_read = counter_read && ctrl_reg.clear_on_read_sel;
  assign clear_now = clear_write || clear_read;

  // Sample acceptance: with measurement enabled, awake conversions always count, diagnostic ones included; sleep ones need a
  // running cyclic timer. A frozen counter takes nothing until it is cleared.
  logic sample_ok;
  assign sample_ok = conv_sample.valid && ctrl_reg.current_meas_enable && !frozen_reg &&
                     (!sleep_mode || cyclic_period_nonzero);

  // Accumulator arithmetic on one extra bit so that both limits can be seen.
  logic signed [`CCNT_ACC_W-1:0] acc_base;
  logic signed [`CCNT_ACC_W:0] acc_sum;
  logic signed [`CCNT_ACC_W-1:0] acc_max;
  logic signed [`CCNT_ACC_W-1:0] acc_min;
  logic pos_ovf;
  logic neg_ovf;
  logic signed [`CCNT_ACC_W-1:0] acc_next;
  logic [`CCNT_TALLY_W-1:0] tally_base;
  logic [`CCNT_TALLY_W:0] tally_sum;
  logic tally_ovf;
  logic [`CCNT_TALLY_W-1:0] tally_next;

  // A clear in the same cycle as a sample restarts from zero and keeps the sample.
  assign acc_base = clear_now ? '0 : acc_reg;
  assign tally_base = clear_now ? '0 : tally_reg;
  assign acc_max = {1'b0, {(`CCNT_ACC_W-1){1'b1}}};
  assign acc_min = {1'b1, {(`CCNT_ACC_W-1){1'b0}}};
  assign acc_sum = {acc_base[`CCNT_ACC_W-1], acc_base} +
                   {{(`CCNT_ACC_W+1-`CCNT_SAMPLE_W){conv_sample.data[`CCNT_SAMPLE_W-1]}}, conv_sample.data};
  assign pos_ovf = sample_ok && (acc_sum[`CCNT_ACC_W:`CCNT_ACC_W-1] == 2'b01);
  assign neg_ovf = sample_ok && (acc_sum[`CCNT_ACC_W:`CCNT_ACC_W-1] == 2'b10);
  assign tally_sum = {1'b0, tally_base} + {{`CCNT_TALLY_W{1'b0}}, 1'b1};
  assign tally_ovf = sample_ok && tally_sum[`CCNT_TALLY_W];

  always_comb begin
    acc_next = acc_base;
    tally_next = tally_base;
    if (sample_ok) begin
      tally_next = tally_sum[`CCNT_TALLY_W-1:0];
      // Clamp mode holds the tally at its top value, so an average never divides by a wrapped count.
      if (tally_ovf && !ctrl_reg.wrap_mode_sel) begin
        tally_next = {`CCNT_TALLY_W{1'b1}};
      end
      if (ctrl_reg.wrap_mode_sel) begin
        acc_next = acc_sum[`CCNT_ACC_W-1:0];
      end else if (pos_ovf) begin
        acc_next = acc_max;
      end else if (neg_ovf) begin
        acc_next = acc_min;
      end else begin
        acc_next = acc_sum[`CCNT_ACC_W-1:0];
      end
    end
  end

  // Threshold is compared against the accumulator magnitude, so a drain and a charge both wake.
  logic [`CCNT_ACC_W:0] acc_mag;
  logic thresh_cross;
  assign acc_mag = acc_next[`CCNT_ACC_W-1] ? ({1'b0, ~acc_next} + {{`CCNT_ACC_W{1'b0}}, 1'b1}) : {1'b0, acc_next};
  assign thresh_cross = sample_ok && sleep_mode && (acc_mag > {1'b0, thresh_reg});

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tally_reg <= '0;
    end else begin
      tally_reg <= tally_next;
    end
  end

  // User copies: the first counter read after an access to another mapped register or a counter write refreshes all three.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_copy_reg <= '0;
      tally_copy_reg <= '0;
    end else if (clear_write) begin
      acc_copy_reg <= '0;
      tally_copy_reg <= '0;
    end else if (take_snapshot) begin
      acc_copy_reg <= acc_reg;
      tally_copy_reg <= tally_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stale_reg <= 1'b1;
    end else if (any_setup && (!is_counter || pwrite)) begin
      stale_reg <= 1'b1;
    end else if (take_snapshot) begin
      stale_reg <= 1'b0;
    end
  end

  // Control register; the clear bit is a strobe and is not stored.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `CCNT_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg.current_meas_enable <= pwdata[`CCNT_CTRL_MEAS_EN];
      ctrl_reg.clear_on_read_sel <= pwdata[`CCNT_CTRL_COR];
      ctrl_reg.wrap_mode_sel <= pwdata[`CCNT_CTRL_WRAP];
      ctrl_reg.fault_mask <= pwdata[`CCNT_CTRL_FAULT_MASK];
      ctrl_reg.wake_mask <= pwdata[`CCNT_CTRL_WAKE_MASK];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      thresh_reg <= `CCNT_THRESH_RESET;
    end else if (thresh_wr) begin
      thresh_reg <= pwdata;
    end
  end

  // Sticky flags: writing 0 clears, writing 1 keeps; a new event in the same cycle wins.
  logic [4:0] flag_clr;
  logic [4:0] flag_set;
  assign flag_clr = flags_wr ? ~pwdata[4:0] : 5'h00;
  always_comb begin
    flag_set = 5'h00;
    flag_set[`CCNT_FLAG_POS] = pos_ovf;
    flag_set[`CCNT_FLAG_NEG] = neg_ovf;
    flag_set[`CCNT_FLAG_TALLY] = tally_ovf;
    flag_set[`CCNT_FLAG_THRESH] = thresh_cross;
    flag_set[`CCNT_FLAG_FAULT] = pos_ovf || neg_ovf || tally_ovf || thresh_cross;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  // Leaving sleep freezes the counter so the charge taken while asleep is not diluted before software sees it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_seen_reg <= 1'b0;
    end else begin
      sleep_seen_reg <= sleep_mode;
    end
  end

  // A sleep exit in the same cycle as a clear wins, so the counter stays frozen though the clear still zeroes it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frozen_reg <= 1'b0;
    end else if (sleep_seen_reg && !sleep_mode) begin
      frozen_reg <= 1'b1;
    end else if (clear_now) begin
      frozen_reg <= 1'b0;
    end
  end

  // Outputs towards the converter and the wake and fault logic.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pga_gain_256_reg <= 1'b0;
    end else begin
      // Sleep measurements always use the top gain, so the select simply follows the power mode.
      pga_gain_256_reg <= sleep_mode;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      continuous_acq_reg <= 1'b1;
    end else begin
      continuous_acq_reg <= !sleep_mode;
    end
  end

  // Masking the wake keeps the threshold flag recorded for software to find later.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_request_reg <= 1'b0;
    end else begin
      wake_request_reg <= sleep_mode && flags_reg.sleep_threshold_flag && !ctrl_reg.wake_mask;
    end
  end

  // The mask hides the fault from the pin only; the sticky bit still records it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_out_reg <= 1'b0;
    end else begin
      fault_out_reg <= flags_reg.accum_overflow_fault && !ctrl_reg.fault_mask;
    end
  end

  // Read data; a refreshing counter read returns the live value that the snapshot takes in the same edge.
  logic [`CCNT_ACC_W-1:0] acc_view;
  logic [`CCNT_TALLY_W-1:0] tally_view;
  logic [31:0] rd_word;
  assign acc_view = stale_reg ? acc_reg : acc_copy_reg;
  assign tally_view = stale_reg ? tally_reg : tally_copy_reg;

  always_comb begin
    rd_word = 32'h00000000;
    unique case (idx)
      `CCNT_IDX_CTRL: begin
        rd_word[`CCNT_CTRL_MEAS_EN] = ctrl_reg.current_meas_enable;
        rd_word[`CCNT_CTRL_COR] = ctrl_reg.clear_on_read_sel;
        rd_word[`CCNT_CTRL_WRAP] = ctrl_reg.wrap_mode_sel;
        rd_word[`CCNT_CTRL_FAULT_MASK] = ctrl_reg.fault_mask;
        rd_word[`CCNT_CTRL_WAKE_MASK] = ctrl_reg.wake_mask;
      end
      `CCNT_IDX_FLAGS: rd_word[4:0] = flags_reg;
      `CCNT_IDX_THRESH: rd_word = thresh_reg;
      `CCNT_IDX_STATUS: begin
        rd_word[`CCNT_STAT_SLEEP] = sleep_mode;
        rd_word[`CCNT_STAT_FROZEN] = frozen_reg;
      end
      `CCNT_IDX_ACC_HIGH: rd_word[`CCNT_HALF_W-1:0] = acc_view[`CCNT_ACC_W-1:`CCNT_HALF_W];
      `CCNT_IDX_ACC_LOW: rd_word[`CCNT_HALF_W-1:0] = acc_view[`CCNT_HALF_W-1:0];
      `CCNT_IDX_TALLY: rd_word[`CCNT_TALLY_W-1:0] = tally_view;
      default: rd_word = 32'h00000000;
    endcase
  end

  // No wait state: the answer is prepared in the setup cycle and stands for the access cycle.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // Unmapped indices answer with an error, so a bad address is seen at once.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup_phase && !is_mapped;
    end
  end

  // Read data is held between transfers and only means something while pready is high.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_phase) begin
      prdata_reg <= (pwrite || !is_mapped) ? 32'h00000000 : rd_word;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pga_gain_256 = pga_gain_256_reg;
  assign continuous_acq = continuous_acq_reg;
  assign wake_request = wake_request_reg;
  assign fault_out = fault_out_reg;

endmodule // ccnt_top

// File: testbench/ccnt_chk.sv
// Port checker for the charge integrator counter.
`include "ccnt_consts.svh"

module ccnt_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CCNT_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Power mode
  input wire logic sleep_mode,
  input wire logic pga_gain_256,
  input wire logic continuous_acq,
  input wire logic wake_request
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  wire logic [9:0] idx = paddr[11:2];
  wire logic cnt_reg = idx inside {`CCNT_IDX_ACC_HIGH, `CCNT_IDX_ACC_LOW, `CCNT_IDX_TALLY};
  wire logic mapped = cnt_reg || (idx inside {`CCNT_IDX_CTRL, `CCNT_IDX_FLAGS, `CCNT_IDX_THRESH, `CCNT_IDX_STATUS});

  property p_ans;
    psel && !penable |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_unmapped;
    psel && !penable && !mapped |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_only;
    pslverr |-> pready && !mapped;
  endproperty
  a_err_only: assert property (p_err_only) else $error("error on mapped access");
  property p_high_zero;
    pready && !pwrite && cnt_reg |-> prdata[31:16] == 16'h0000;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("counter word upper half not zero");
  property p_gain;
    1'b1 |=> pga_gain_256 == $past(sleep_mode);
  endproperty
  a_gain: assert property (p_gain) else $error("gain select does not follow sleep");
  property p_cont;
    1'b1 |=> continuous_acq == !$past(sleep_mode);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous acquisition wrong");
  property p_wake;
    wake_request |-> $past(sleep_mode);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request outside sleep");
endmodule // ccnt_chk

bind ccnt_top ccnt_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_mode(sleep_mode), .pga_gain_256(pga_gain_256), .continuous_acq(continuous_acq),
  .wake_request(wake_request));

// File: testbench/tb_top.sv
// Self-checking bench for the charge integrator counter.
`include "ccnt_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ccnt_pkg::ccnt_sample_t conv_sample = '0;
  logic sleep_mode = 1'b0;
  logic cyc_nz = 1'b0;
  logic pga_gain_256;
  logic continuous_acq;
  logic wake_request;
  logic fault_out;
  logic [31:0] rdata;
  logic rerr;
  int miscompares = 0;
  int n_compared = 0;

  always #50 sys_clk = ~sys_clk;

  ccnt_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_sample(conv_sample), .sleep_mode(sleep_mode), .cyclic_period_nonzero(cyc_nz),
    .pga_gain_256(pga_gain_256), .continuous_acq(continuous_acq), .wake_request(wake_request),
    .fault_out(fault_out));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // Entered right after a rising edge; the request stands until pready is sampled high.
  // One idle edge follows, so the next call never drives psel twice in one step.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), rdata, exp);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  // The high copy is read first so that a stale snapshot is refreshed by it.
  task automatic cnt(input logic [31:0] acc, input logic [15:0] tl);
    rd(`CCNT_IDX_ACC_HIGH, {16'h0, acc[31:16]});
    rd(`CCNT_IDX_ACC_LOW, {16'h0, acc[15:0]});
    rd(`CCNT_IDX_TALLY, {16'h0, tl});
  endtask

  task automatic smp(input logic [15:0] d, input int n);
    conv_sample <= {1'b1, d};
    repeat (n) @(posedge sys_clk);
    conv_sample <= '0;
    @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(`CCNT_IDX_CTRL, 32'h0);
    rd(`CCNT_IDX_THRESH, 32'h7fffffff);
    rd(`CCNT_IDX_FLAGS, 32'h0);
    rd(10'h3ff, 32'h0);
    chk("slverr", {31'h0, rerr}, 32'h1);
    smp(16'h0009, 1);
    wr(`CCNT_IDX_CTRL, 32'h1);
    smp(16'h0005, 1);
    smp(16'hfffe, 1);
    smp(16'h000a, 1);
    cnt(32'd13, 16'd3);
    $display("test accumulate done");
    smp(16'h0004, 1);
    rd(`CCNT_IDX_ACC_LOW, 32'd13);
    rd(`CCNT_IDX_CTRL, 32'h1);
    cnt(32'd17, 16'd4);
    wr(`CCNT_IDX_CTRL, 32'h3);
    cnt(32'd0, 16'd0);
    $display("test snapshot done");
    // Long enough to pass both the tally limit and the positive accumulator limit.
    smp(16'h7fff, 65540);
    rd(`CCNT_IDX_FLAGS, 32'h15);
    cnt(32'h7fffffff, 16'hffff);
    chk("fault_out", {31'h0, fault_out}, 32'h1);
    wr(`CCNT_IDX_CTRL, 32'h11);
    repeat (2) @(posedge sys_clk);
    chk("fault_out", {31'h0, fault_out}, 32'h0);
    $display("test clamp done");
    wr(`CCNT_IDX_CTRL, 32'h9);
    smp(16'h0001, 1);
    cnt(32'h80000000, 16'h0000);
    wr(`CCNT_IDX_FLAGS, 32'h0);
    rd(`CCNT_IDX_FLAGS, 32'h0);
    @(posedge sys_clk);
    chk("fault_out", {31'h0, fault_out}, 32'h0);
    $display("test rollover done");
    wr(`CCNT_IDX_CTRL, 32'hf);
    smp(16'h0003, 2);
    rd(`CCNT_IDX_ACC_LOW, 32'd6);
    rd(`CCNT_IDX_TALLY, 32'd2);
    rd(`CCNT_IDX_CTRL, 32'hd);
    rd(`CCNT_IDX_TALLY, 32'd0);
    $display("test clear on read done");
    wr(`CCNT_IDX_CTRL, 32'h3);
    wr(`CCNT_IDX_THRESH, 32'd100);
    sleep_mode <= 1'b1;
    smp(16'h0032, 1);
    cyc_nz <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("gain", {31'h0, pga_gain_256}, 32'h1);
    chk("cont", {31'h0, continuous_acq}, 32'h0);
    smp(16'h00c8, 1);
    repeat (2) @(posedge sys_clk);
    chk("wake", {31'h0, wake_request}, 32'h1);
    chk("fault_out", {31'h0, fault_out}, 32'h1);
    wr(`CCNT_IDX_CTRL, 32'h21);
    @(posedge sys_clk);
    chk("wake", {31'h0, wake_request}, 32'h0);
    sleep_mode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("cont", {31'h0, continuous_acq}, 32'h1);
    rd(`CCNT_IDX_STATUS, 32'h2);
    smp(16'h0007, 1);
    cnt(32'd200, 16'd1);
    rd(`CCNT_IDX_FLAGS, 32'h18);
    wr(`CCNT_IDX_CTRL, 32'h3);
    smp(16'h0007, 1);
    cnt(32'd7, 16'd1);
    $display("test sleep done");
    print_verdict();
  end
endmodule // tb_top
